// ===== core/psm_defines.svh
`ifndef PSM_DEFINES_SVH
`define PSM_DEFINES_SVH

// ----------------------------------------
// Register byte offsets.
// ----------------------------------------
`define PSM_GPIO_EN_OFS  8'h00
`define PSM_GPIO_DIR_OFS 8'h04
`define PSM_GPIO_OUT_OFS 8'h08
`define PSM_GPIO_IN_OFS  8'h0C
`define PSM_STRAP_OFS    8'h10

// ----------------------------------------
// Reset values and field positions.
// ----------------------------------------
`define PSM_GPIO_RST     16'h0000
`define PSM_ST_WIDE_BIT  0
`define PSM_ST_CELL_BIT  1
`define PSM_ST_PCI_BIT   2
`define PSM_ST_DONE_BIT  3
`define PSM_CLK4_PIN     1
`define PSM_CLK6_PIN     2
`define PSM_SERIAL_TWO_EXTERNAL_CLOCK_PIN    8
`define PSM_PCI_LO_PIN   9
`define PSM_PCI_HI_PIN   15

// ----------------------------------------
// Bus responses.
// ----------------------------------------
`define PSM_RESP_OKAY    2'h0
`define PSM_RESP_DECERR  2'h3

`endif

// ===== core/psm_pkg.sv
// ----------------------------------------
// Shared types.
// ----------------------------------------
package psm_pkg;

    // Strap levels as captured after reset.
    typedef struct packed {
        logic pci_en;   // PCI owns the shared host pins.
        logic cell_en;  // Cell port owns the shared serial-one pins.
        logic wide;     // Host port is 32 bits wide.
    } psm_strap_t;

    // Capture sequencer states.
    typedef enum logic {
        PSM_CAP_WAIT,
        PSM_CAP_DONE
    } psm_cap_state_t;

    // Register select after address decode.
    typedef enum logic [2:0] {
        PSM_REG_EN,
        PSM_REG_DIR,
        PSM_REG_OUT,
        PSM_REG_IN,
        PSM_REG_STRAP,
        PSM_REG_NONE
    } psm_reg_t;

endpackage : psm_pkg

// ===== core/psm_strap_if.sv
// ----------------------------------------
// Captured strap levels between modules.
// ----------------------------------------
interface psm_strap_if;
    psm_pkg::psm_strap_t straps;    // Frozen strap levels.
    logic                captured;  // High once straps are frozen.

    modport src (output straps, output captured);
    modport dst (input straps, input captured);
endinterface : psm_strap_if

// ===== core/psm_strap_capture.sv
`include "psm_defines.svh"

// ----------------------------------------
// Strap synchroniser and one-shot capture.
// ----------------------------------------
module psm_strap_capture (
    input  wire logic   clk,
    input  wire logic   reset,
    input  wire logic   host_width_strap_pin,
    input  wire logic   cell_port_enable_strap,
    input  wire logic   pci_enable_strap,
    psm_strap_if.src    cap
);
    import psm_pkg::*;

    logic [2:0]          meta_reg;   // First synchroniser stage.
    logic [2:0]          sync_reg;   // Second synchroniser stage.
    psm_cap_state_t      state_reg;  // Capture sequencer.
    psm_strap_t          strap_reg;  // Frozen strap levels.

    // The chain runs through reset so that it is settled by the release.
    always_ff @(posedge clk) begin
        meta_reg <= {pci_enable_strap, cell_port_enable_strap, host_width_strap_pin};
        sync_reg <= meta_reg;
    end

    // R12 capture once
    // Straps are caught on the first edge after release, then held.
    always_ff @(posedge clk) begin
        if (reset) begin
            state_reg <= PSM_CAP_WAIT;
            strap_reg <= '0;
        end else begin
            case (state_reg)
                PSM_CAP_WAIT: begin
                    strap_reg <= sync_reg;
                    state_reg <= PSM_CAP_DONE;
                end
                PSM_CAP_DONE: begin
                    state_reg <= PSM_CAP_DONE;
                end
                default: begin
                    state_reg <= PSM_CAP_WAIT;
                end
            endcase
        end
    end

    assign cap.straps   = strap_reg;
    assign cap.captured = (state_reg == PSM_CAP_DONE);

    property p_cap_first;
        @(posedge clk) disable iff (reset) !cap.captured |=> cap.captured;
    endproperty
    a_cap_first: assert property (p_cap_first) else $error("straps not captured"); // R12

    property p_cap_frozen;
        @(posedge clk) disable iff (reset) cap.captured |=> $stable(strap_reg);
    endproperty
    a_cap_frozen: assert property (p_cap_frozen) else $error("straps changed"); // R12

endmodule : psm_strap_capture

// ===== core/psm_pin_mux.sv
// Local design decisions: the register addresses and the AXI4-Lite interface to the registers.
`include "psm_defines.svh"

// What this block does
// R1 - Narrow host port floats upper data pins
// R2 - Wide host port drives all data pins
// R3 - Software pin function changes anytime
// R4 - Strapped pins owned by one peripheral
// R5 - GPIO only when enable bit set
// R6 - Direction bit zero input, one output
// R7 - Upper GPIO needs PCI strap off
// R8 - Cell strap low gives serial one
// R9 - Others drive non-strap pins default
// R10 - Cell strap high floats solo pins
// R11 - PCI strap off gives host port
// R12 - Straps captured once at release

// ----------------------------------------
// Pin-function multiplexer with strap capture.
// ----------------------------------------
module psm_pin_mux #(
    parameter int GPIO_W = 16,   // General-purpose pin count.
    parameter int SHR_W  = 4,    // Serial-one pins shared with cell port.
    parameter int SOLO_W = 3     // Standalone serial-one pins.
) (
    input  wire logic                clk,
    input  wire logic                reset,
    input  wire logic [7:0]          s_axi_awaddr,
    input  wire logic                s_axi_awvalid,
    output wire logic                s_axi_awready,
    input  wire logic [31:0]         s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    input  wire logic                s_axi_wvalid,
    output wire logic                s_axi_wready,
    output wire logic [1:0]          s_axi_bresp,
    output wire logic                s_axi_bvalid,
    input  wire logic                s_axi_bready,
    input  wire logic [7:0]          s_axi_araddr,
    input  wire logic                s_axi_arvalid,
    output wire logic                s_axi_arready,
    output wire logic [31:0]         s_axi_rdata,
    output wire logic [1:0]          s_axi_rresp,
    output wire logic                s_axi_rvalid,
    input  wire logic                s_axi_rready,
    input  wire logic                host_width_strap_pin,
    input  wire logic                cell_port_enable_strap,
    input  wire logic                pci_enable_strap,
    input  wire logic [31:0]         host_port_dout,
    input  wire logic                host_port_doe,
    input  wire logic [31:0]         pci_ad_out,
    input  wire logic                pci_ad_oe,
    output wire logic [31:0]         host_data_pins_out,
    output wire logic [31:0]         host_data_pins_oe,
    output wire logic                host_port_wide_mode,
    output wire logic                host_port_narrow_mode,
    output wire logic                pci_port_enabled,
    input  wire logic [SHR_W-1:0]    sp1_shared_out,
    input  wire logic [SHR_W-1:0]    sp1_shared_oe,
    input  wire logic [SHR_W-1:0]    cell_shared_out,
    input  wire logic [SHR_W-1:0]    cell_shared_oe,
    input  wire logic [SOLO_W-1:0]   sp1_solo_out,
    input  wire logic [SOLO_W-1:0]   sp1_solo_oe,
    output wire logic [SHR_W-1:0]    sp1_cell_pins_out,
    output wire logic [SHR_W-1:0]    sp1_cell_pins_oe,
    output wire logic [SOLO_W-1:0]   sp1_solo_pins_out,
    output wire logic [SOLO_W-1:0]   sp1_solo_pins_oe,
    output wire logic                buffered_serial_port_one_enabled,
    output wire logic                cell_port_enabled,
    input  wire logic                cpu_clock_div4_output,
    input  wire logic                cpu_clock_div6_output,
    input  wire logic [6:0]          pci_gp_out,
    input  wire logic [6:0]          pci_gp_oe,
    input  wire logic [GPIO_W-1:0]   gpio_pins_in,
    output wire logic [GPIO_W-1:0]   gpio_pins_out,
    output wire logic [GPIO_W-1:0]   gpio_pins_oe,
    output wire logic                serial_two_clock_selected
);
    import psm_pkg::*;

    // ----------------------------------------
    // Helper functions.
    // ----------------------------------------

    // Address decode, shared by the read and write paths.
    function automatic psm_reg_t decode(input logic [7:0] addr);
        case (addr)
            `PSM_GPIO_EN_OFS:  decode = PSM_REG_EN;
            `PSM_GPIO_DIR_OFS: decode = PSM_REG_DIR;
            `PSM_GPIO_OUT_OFS: decode = PSM_REG_OUT;
            `PSM_GPIO_IN_OFS:  decode = PSM_REG_IN;
            `PSM_STRAP_OFS:    decode = PSM_REG_STRAP;
            default:           decode = PSM_REG_NONE;
        endcase
    endfunction : decode

    // Byte-lane merge for the 16-bit registers; upper lanes are ignored.
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                            input logic [3:0] strb);
        merge16[7:0]  = strb[0] ? d[7:0]  : old[7:0];
        merge16[15:8] = strb[1] ? d[15:8] : old[15:8];
    endfunction : merge16

    // Pins that the PCI port claims when its strap is set.
    function automatic logic is_pci_pin(input int idx);
        is_pci_pin = (idx >= `PSM_PCI_LO_PIN) && (idx <= `PSM_PCI_HI_PIN);
    endfunction : is_pci_pin

    // ----------------------------------------
    // Strap capture.
    // ----------------------------------------
    psm_strap_if strap_bus ();

    psm_strap_capture u_cap (
        .clk                    (clk),
        .reset                  (reset),
        .host_width_strap_pin   (host_width_strap_pin),
        .cell_port_enable_strap (cell_port_enable_strap),
        .pci_enable_strap       (pci_enable_strap),
        .cap                    (strap_bus.src)
    );

    wire logic wide    = strap_bus.straps.wide;     // Wide host port.
    wire logic cell_en = strap_bus.straps.cell_en;  // Cell port owns pins.
    wire logic pci_en  = strap_bus.straps.pci_en;   // PCI owns host pins.

    // ----------------------------------------
    // Register bus state.
    // ----------------------------------------
    logic [7:0]          aw_addr_reg;   // Held write address.
    logic                aw_full_reg;   // Write address waiting.
    logic [31:0]         w_data_reg;    // Held write data.
    logic [3:0]          w_strb_reg;    // Held byte enables.
    logic                w_full_reg;    // Write data waiting.
    logic                bvalid_reg;    // Write response pending.
    logic [1:0]          bresp_reg;     // Write response code.
    logic                rvalid_reg;    // Read response pending.
    logic [31:0]         rdata_reg;     // Read data.
    logic [1:0]          rresp_reg;     // Read response code.
    logic [GPIO_W-1:0]   gpio_en_reg;   // Per-pin GPIO enable.
    logic [GPIO_W-1:0]   gpio_dir_reg;  // Per-pin direction, one drives.
    logic [GPIO_W-1:0]   gpio_out_reg;  // Per-pin output level.
    logic [GPIO_W-1:0]   gp_meta_reg;   // First GPIO input stage.
    logic [GPIO_W-1:0]   gp_sync_reg;   // Second GPIO input stage.

    // Address and data are taken in either order; the commit waits for both.
    wire logic     aw_take = s_axi_awvalid & ~aw_full_reg;
    wire logic     w_take  = s_axi_wvalid & ~w_full_reg;
    wire logic     do_wr   = aw_full_reg & w_full_reg & ~bvalid_reg;
    wire logic     ar_take = s_axi_arvalid & ~rvalid_reg;
    wire psm_reg_t wr_sel  = decode(aw_addr_reg);
    wire psm_reg_t rd_sel  = decode(s_axi_araddr);

    assign s_axi_awready = ~aw_full_reg;
    assign s_axi_wready  = ~w_full_reg;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;
    assign s_axi_arready = ~rvalid_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rdata   = rdata_reg;
    assign s_axi_rresp   = rresp_reg;

    // Write channel holding registers and the response.
    always_ff @(posedge clk) begin
        if (reset) begin
            aw_full_reg <= 1'b0;
            w_full_reg  <= 1'b0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= `PSM_RESP_OKAY;
            aw_addr_reg <= 8'h00;
            w_data_reg  <= 32'h00000000;
            w_strb_reg  <= 4'h0;
        end else begin
            if (aw_take) begin
                aw_addr_reg <= s_axi_awaddr;
                aw_full_reg <= 1'b1;
            end
            if (w_take) begin
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
                w_full_reg <= 1'b1;
            end
            if (do_wr) begin
                aw_full_reg <= 1'b0;
                w_full_reg  <= 1'b0;
                bvalid_reg  <= 1'b1;
                bresp_reg   <= (wr_sel == PSM_REG_NONE) ? `PSM_RESP_DECERR : `PSM_RESP_OKAY;
            end else if (s_axi_bready) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    // R3 live reconfiguration
    // Control bits take effect on the commit edge, with no reset needed.
    always_ff @(posedge clk) begin
        if (reset) begin
            gpio_en_reg  <= `PSM_GPIO_RST;
            gpio_dir_reg <= `PSM_GPIO_RST;
            gpio_out_reg <= `PSM_GPIO_RST;
        end else if (do_wr) begin
            if (wr_sel == PSM_REG_EN)  gpio_en_reg  <= merge16(gpio_en_reg, w_data_reg, w_strb_reg);
            if (wr_sel == PSM_REG_DIR) gpio_dir_reg <= merge16(gpio_dir_reg, w_data_reg, w_strb_reg);
            if (wr_sel == PSM_REG_OUT) gpio_out_reg <= merge16(gpio_out_reg, w_data_reg, w_strb_reg);
        end
    end

    // Read path; the status word shows the frozen straps.
    wire logic [31:0] strap_word = {28'h0000000, strap_bus.captured, pci_en, cell_en, wide};
    wire logic [31:0] rd_word    = (rd_sel == PSM_REG_EN)    ? {16'h0000, gpio_en_reg}  :
                                   (rd_sel == PSM_REG_DIR)   ? {16'h0000, gpio_dir_reg} :
                                   (rd_sel == PSM_REG_OUT)   ? {16'h0000, gpio_out_reg} :
                                   (rd_sel == PSM_REG_IN)    ? {16'h0000, gp_sync_reg}  :
                                   (rd_sel == PSM_REG_STRAP) ? strap_word : 32'h00000000;

    // Read response register.
    always_ff @(posedge clk) begin
        if (reset) begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= 32'h00000000;
            rresp_reg  <= `PSM_RESP_OKAY;
        end else if (ar_take) begin
            rvalid_reg <= 1'b1;
            rdata_reg  <= rd_word;
            rresp_reg  <= (rd_sel == PSM_REG_NONE) ? `PSM_RESP_DECERR : `PSM_RESP_OKAY;
        end else if (s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    // GPIO inputs come from pins, so two stages before the read mux.
    always_ff @(posedge clk) begin
        gp_meta_reg <= gpio_pins_in;
        gp_sync_reg <= gp_meta_reg;
    end

    // ----------------------------------------
    // Pin selection.
    // ----------------------------------------
    logic [31:0]         hd_out_reg;   // Host data pin levels.
    logic [31:0]         hd_oe_reg;    // Host data pin enables.
    logic [SHR_W-1:0]    shr_out_reg;  // Shared serial/cell levels.
    logic [SHR_W-1:0]    shr_oe_reg;   // Shared serial/cell enables.
    logic [SOLO_W-1:0]   solo_out_reg; // Standalone serial levels.
    logic [SOLO_W-1:0]   solo_oe_reg;  // Standalone serial enables.
    logic [GPIO_W-1:0]   gp_out_reg;   // GPIO pin levels.
    logic [GPIO_W-1:0]   gp_oe_reg;    // GPIO pin enables.
    logic [GPIO_W-1:0]   dflt_out;     // Default function levels.
    logic [GPIO_W-1:0]   dflt_oe;      // Default function enables.
    logic [GPIO_W-1:0]   gp_use;       // Pin runs as GPIO.

    // R11 host owns pins
    // Without PCI the host port has the shared data pins.
    wire logic [31:0] hd_out_next = pci_en ? pci_ad_out : host_port_dout;
    // R1 upper half floats
    // R2 full width drive
    wire logic [15:0] hd_hi_oe    = wide ? {16{host_port_doe}} : 16'h0000;
    wire logic [31:0] hd_oe_next  = pci_en ? {32{pci_ad_oe}} : {hd_hi_oe, {16{host_port_doe}}};

    // R8 serial one default
    // R4 one owner only
    wire logic [SHR_W-1:0]  shr_out_next  = cell_en ? cell_shared_out : sp1_shared_out;
    wire logic [SHR_W-1:0]  shr_oe_next   = cell_en ? cell_shared_oe : sp1_shared_oe;
    // R10 solo pins float
    wire logic [SOLO_W-1:0] solo_oe_next  = cell_en ? '0 : sp1_solo_oe;

    // Per-pin GPIO selection.
    generate
        for (genvar i = 0; i < GPIO_W; i++) begin : g_pin
            // R7 PCI pins gated
            // R5 enable gates GPIO
            assign gp_use[i] = gpio_en_reg[i] & ~(is_pci_pin(i) & pci_en);
            if (i == `PSM_CLK4_PIN) begin : g_c4
                assign dflt_out[i] = cpu_clock_div4_output;
                assign dflt_oe[i]  = 1'b1;
            end else if (i == `PSM_CLK6_PIN) begin : g_c6
                assign dflt_out[i] = cpu_clock_div6_output;
                assign dflt_oe[i]  = 1'b1;
            end else if (is_pci_pin(i)) begin : g_pci
                assign dflt_out[i] = pci_en & pci_gp_out[i-`PSM_PCI_LO_PIN];
                assign dflt_oe[i]  = pci_en & pci_gp_oe[i-`PSM_PCI_LO_PIN];
            end else begin : g_none
                // Input-only or no default function, so never driven.
                assign dflt_out[i] = 1'b0;
                assign dflt_oe[i]  = 1'b0;
            end
        end
    endgenerate

    // R6 direction bit
    wire logic [GPIO_W-1:0] gp_out_next = (gp_use & gpio_out_reg) | (~gp_use & dflt_out);
    wire logic [GPIO_W-1:0] gp_oe_next  = (gp_use & gpio_dir_reg) | (~gp_use & dflt_oe);

    // All pin drives are registered, costing one cycle of latency.
    always_ff @(posedge clk) begin
        if (reset) begin
            hd_out_reg   <= 32'h00000000;
            hd_oe_reg    <= 32'h00000000;
            shr_out_reg  <= '0;
            shr_oe_reg   <= '0;
            solo_out_reg <= '0;
            solo_oe_reg  <= '0;
            gp_out_reg   <= '0;
            gp_oe_reg    <= '0;
        end else begin
            hd_out_reg   <= hd_out_next;
            hd_oe_reg    <= hd_oe_next;
            shr_out_reg  <= shr_out_next;
            shr_oe_reg   <= shr_oe_next;
            solo_out_reg <= sp1_solo_out;
            solo_oe_reg  <= solo_oe_next;
            gp_out_reg   <= gp_out_next;
            gp_oe_reg    <= gp_oe_next;
        end
    end

    assign host_data_pins_out               = hd_out_reg;
    assign host_data_pins_oe                = hd_oe_reg;
    assign sp1_cell_pins_out                = shr_out_reg;
    assign sp1_cell_pins_oe                 = shr_oe_reg;
    assign sp1_solo_pins_out                = solo_out_reg;
    assign sp1_solo_pins_oe                 = solo_oe_reg;
    assign gpio_pins_out                    = gp_out_reg;
    assign gpio_pins_oe                     = gp_oe_reg;
    assign host_port_wide_mode              = ~pci_en & wide;
    assign host_port_narrow_mode            = ~pci_en & ~wide;
    assign pci_port_enabled                 = pci_en;
    assign buffered_serial_port_one_enabled = ~cell_en;
    assign cell_port_enabled                = cell_en;
    assign serial_two_clock_selected        = ~gpio_en_reg[`PSM_SERIAL_TWO_EXTERNAL_CLOCK_PIN];

    // ----------------------------------------
    // Assertions.
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    property p_narrow;
        !pci_en && !wide |=> host_data_pins_oe[31:16] == 16'h0000;
    endproperty
    a_narrow: assert property (p_narrow) else $error("upper host pins driven"); // R1

    property p_wide;
        !pci_en && wide && host_port_doe |=> &host_data_pins_oe;
    endproperty
    a_wide: assert property (p_wide) else $error("wide host pins not driven"); // R2

    property p_live;
        do_wr && wr_sel == PSM_REG_EN && w_strb_reg[0] |=> ##1 gpio_pins_oe[0] == (gpio_en_reg[0] ?
            $past(gpio_dir_reg[0]) : 1'b0);
    endproperty
    a_live: assert property (p_live) else $error("pin function not updated"); // R3

    property p_owner;
        cell_en |=> sp1_cell_pins_oe == $past(cell_shared_oe) && !buffered_serial_port_one_enabled;
    endproperty
    a_owner: assert property (p_owner) else $error("two owners"); // R4

    property p_default_clk;
        !gpio_en_reg[1] |=> gpio_pins_oe[1] && gpio_pins_out[1] == $past(cpu_clock_div4_output);
    endproperty
    a_default_clk: assert property (p_default_clk) else $error("clock pin lost"); // R5

    property p_dir;
        gpio_en_reg[0] |=> gpio_pins_oe[0] == $past(gpio_dir_reg[0]);
    endproperty
    a_dir: assert property (p_dir) else $error("direction wrong"); // R6

    property p_pci_gp;
        pci_en |=> gpio_pins_oe[15:9] == $past(pci_gp_oe);
    endproperty
    a_pci_gp: assert property (p_pci_gp) else $error("PCI pins taken by GPIO"); // R7

    property p_sp1;
        !cell_en |=> sp1_cell_pins_oe == $past(sp1_shared_oe);
    endproperty
    a_sp1: assert property (p_sp1) else $error("serial one not on pins"); // R8

    property p_solo;
        cell_en |=> sp1_solo_pins_oe == '0;
    endproperty
    a_solo: assert property (p_solo) else $error("solo pins driven"); // R10

    property p_host;
        !pci_en |=> host_data_pins_out == $past(host_port_dout);
    endproperty
    a_host: assert property (p_host) else $error("host data not on pins"); // R11

    c_wide: cover property (strap_bus.captured && wide);
    c_cell: cover property (strap_bus.captured && cell_en);
    c_gpio_out: cover property (gpio_pins_oe[9] && gp_use[9]);

endmodule : psm_pin_mux

// ===== testbench/psm_strap_model.sv
// ----------------------------------------
// Board strap resistors and reset-time pin driver.
// ----------------------------------------
module psm_strap_model (
    input  wire logic       reset,
    input  wire logic [2:0] lvl,
    input  wire logic [2:0] noise,
    output wire logic       host_width_strap_pin,
    output wire logic       cell_port_enable_strap,
    output wire logic       pci_enable_strap
);
    timeunit 1ns;
    timeprecision 1ps;
    // defaults during reset
    // Levels hold through reset; afterwards the pins may wiggle, which the block must ignore.
    assign {pci_enable_strap, cell_port_enable_strap, host_width_strap_pin} = reset ? lvl : lvl ^ noise;
endmodule : psm_strap_model

// ===== testbench/tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, reset = 1'b1, host_port_doe, pci_ad_oe;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, host_port_dout, pci_ad_out, host_data_pins_out, host_data_pins_oe;
    logic [3:0] s_axi_wstrb = 4'hF, sp1_shared_out, sp1_shared_oe, cell_shared_out, cell_shared_oe;
    logic [3:0] sp1_cell_pins_out, sp1_cell_pins_oe;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, cpu_clock_div4_output;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [2:0] sp1_solo_out, sp1_solo_oe, sp1_solo_pins_out, sp1_solo_pins_oe, lvl = 3'h0, noise = 3'h0;
    logic host_width_strap_pin, cell_port_enable_strap, pci_enable_strap, host_port_wide_mode, host_port_narrow_mode;
    logic pci_port_enabled, buffered_serial_port_one_enabled, cell_port_enabled, cpu_clock_div6_output;
    logic serial_two_clock_selected;
    logic [6:0] pci_gp_out, pci_gp_oe;
    logic [15:0] gpio_pins_in, gpio_pins_out, gpio_pins_oe, en = 16'h0, dir = 16'h0, dout = 16'h0;
    logic [34:0] q[$];
    int fail_count = 0, checked = 0;
    psm_pin_mux psm_pin_mux_inst (.*);
    psm_strap_model psm_strap_model_inst (.*);
    always #25 clk = ~clk;
    task chk(input string n, input logic [63:0] e, input logic [63:0] g);
        checked++;
        if (g !== e) begin
            fail_count++;
            $display("mismatch %s exp %h got %h", n, e, g);
        end
    endtask : chk
    task end_sim;
        if (fail_count == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : end_sim
    // Each bus answer is compared with the oldest note left by the driver.
    always @(posedge clk) begin
        if ((s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready)) begin
            if (q.size() == 0) chk("queue", 0, 1);
            else if (q[0][34]) chk("rd", q.pop_front(), {1'b1, s_axi_rresp, s_axi_rdata});
            else chk("wr", q.pop_front(), {1'b0, s_axi_bresp, 32'h0});
        end
    end
    task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        q.push_back({1'b0, r, 32'h0});
        @(posedge clk);
        {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 3'b111};
        do begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
    endtask : wr
    task rd(input logic [7:0] a, input logic [33:0] e);
        q.push_back({1'b1, e});
        @(posedge clk);
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
        do begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
    endtask : rd
    task stir;
        {sp1_shared_out, sp1_shared_oe, cell_shared_out, cell_shared_oe, sp1_solo_out, sp1_solo_oe} <= 22'($urandom);
        {pci_gp_out, pci_gp_oe, gpio_pins_in, cpu_clock_div4_output, cpu_clock_div6_output} <= $urandom;
        {host_port_dout, pci_ad_out, host_port_doe, pci_ad_oe} <= {$urandom, $urandom, 2'($urandom)};
    endtask : stir
    // Pin outputs lag their inputs by one cycle, so four edges is ample settling.
    task pins;
        logic [31:0] ho;
        logic [15:0] eo, ev;
        @(posedge clk);
        stir();
        repeat (4) @(posedge clk);
        @(negedge clk);
        ho = {{16{lvl[0] | lvl[2]}}, 16'hFFFF};
        for (int i = 0; i < 16; i++) begin
            if (en[i] && !(lvl[2] && i >= 9)) {eo[i], ev[i]} = {dir[i], dout[i]};
            else if (i == 1 || i == 2) {eo[i], ev[i]} = {1'b1, i == 1 ? cpu_clock_div4_output : cpu_clock_div6_output};
            else if (i >= 9 && lvl[2]) {eo[i], ev[i]} = {pci_gp_oe[i-9], pci_gp_out[i-9]};
            else {eo[i], ev[i]} = 2'b00;
        end
        chk("host_oe", ho & {32{lvl[2] ? pci_ad_oe : host_port_doe}}, host_data_pins_oe);
        chk("host_out", (lvl[2] ? pci_ad_out : host_port_dout) & ho, host_data_pins_out & ho);
        chk("modes", {lvl[0] & !lvl[2], !(lvl[0] | lvl[2]), lvl[2], !lvl[1], lvl[1]}, {host_port_wide_mode,
            host_port_narrow_mode, pci_port_enabled, buffered_serial_port_one_enabled, cell_port_enabled});
        chk("shared", lvl[1] ? {cell_shared_oe, cell_shared_out & cell_shared_oe, 6'h0} : {sp1_shared_oe,
            sp1_shared_out & sp1_shared_oe, sp1_solo_oe, sp1_solo_out & sp1_solo_oe}, {sp1_cell_pins_oe,
            sp1_cell_pins_out & sp1_cell_pins_oe, sp1_solo_pins_oe, sp1_solo_pins_out & sp1_solo_pins_oe});
        chk("gpio_oe", eo, gpio_pins_oe);
        chk("gpio_out", ev & eo, gpio_pins_out & eo);
        chk("serial_two_external_clock", !en[8], serial_two_clock_selected);
    endtask : pins
    task gpio(input logic [15:0] e, input logic [15:0] d, input logic [15:0] o);
        {en, dir, dout} = {e, d, o};
        wr(8'h00, {16'($urandom), e}, 2'h0);
        wr(8'h04, {16'h0, d}, 2'h0);
        wr(8'h08, {16'h0, o}, 2'h0);
        rd(8'h00, {18'h0, e});
        pins();
    endtask : gpio
    task do_reset(input logic [2:0] l);
        @(posedge clk);
        {reset, lvl, noise, en, dir, dout} <= {1'b1, l, 3'h0, 48'h0};
        repeat (8) @(posedge clk);
        reset <= 1'b0;
    endtask : do_reset
    initial begin
        void'($urandom(81));
        stir();
        do_reset(3'b000);
        rd(8'h10, 34'h8);
        pins();
        noise <= 3'h7;
        pins();
        gpio(16'hFFFF, 16'hFFFF, 16'($urandom));
        repeat (3) gpio(16'($urandom), 16'($urandom), 16'($urandom));
        rd(8'h0C, {18'h0, gpio_pins_in});
        wr(8'h14, 32'h1, 2'h3);
        rd(8'h14, {2'h3, 32'h0});
        wr(8'h10, 32'h0, 2'h0);
        rd(8'h10, 34'h8);
        do_reset(3'b111);
        rd(8'h00, 34'h0);
        rd(8'h10, 34'hF);
        gpio(16'hFFFF, 16'h0F0F, 16'($urandom));
        repeat (2) @(posedge clk);
        end_sim();
    end
    initial begin
        repeat (5000) @(posedge clk);
        fail_count++;
        end_sim();
    end
endmodule : tb_top
